// >>> hw/wdt_pkg.sv
// Package: register map, fields and timing for the runaway watchdog
package wdt_pkg;
    // Register offsets (byte addresses)
    localparam logic [3:0] OFS_CTRL    = 4'h0;
    localparam logic [3:0] OFS_RESTART = 4'h4;
    localparam logic [3:0] OFS_COUNT   = 4'h8;
    localparam logic [3:0] OFS_IRQ_ST  = 4'hc;
    localparam logic [3:0] OFS_IRQ_CLR = 4'hd;
    localparam logic [3:0] OFS_IRQ_EN  = 4'he;
    // Control register fields
    localparam int BIT_PRESCALE = 0;
    localparam int BIT_ACTION   = 1;
    localparam int BIT_SUBCLK   = 2;
    // Status register fields
    localparam int ST_UNDERFLOW = 0;
    localparam int ST_WIDTH     = 1;
    // Counter and prescaler figures
    localparam int          CNT_W      = 15;
    localparam logic [14:0] CNT_RELOAD = 15'h7fff;
    localparam int          PRE_W      = 7;
    localparam logic [6:0]  DIV_SLOW   = 7'h7f;
    localparam logic [6:0]  DIV_FAST   = 7'h0f;
    localparam logic [6:0]  DIV_SUB    = 7'h01;
    localparam logic [7:0]  CTRL_RST   = 8'h00;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_HALT = 2'b11
    } wdt_state_t;
endpackage

// >>> hw/program_runaway_watchdog.sv
// Runaway watchdog: prescaler, 15-bit down-counter and register port
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ns

// Operation
// (R1) A 15-bit down-counter steps once per prescaler output pulse.
// (R2) Underflow raises an interrupt or a reset, per the action bit.
// (R3) Action bit can only be set to one; zero writes are ignored.
// (R4) On main clock the prescaler divides by 16 or 128.
// (R5) On sub-clock the prescaler always divides by 2.
// (R6) Period is division ratio times 32768 CPU clocks.
// (R7) Any restart register write reinitialises the counter.
// (R8) System reset initialises the prescaler.
// (R9) Counter and prescaler idle after reset until first restart write.
// (R10) Stop, wait and hold freeze counter and prescaler.
// (R11) After a freeze, counting resumes from the held value.
// (R12) Software must restart the watchdog after its interrupt.
// (R13) Restart reloads 0x7fff whatever data is written.
// (R14) In interrupt action, counting continues after underflow by wrapping.
module program_runaway_watchdog
    import wdt_pkg::*;
#(
    parameter int COUNT_W = CNT_W
) (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // Register port
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // Power state of the chip
    input  wire logic       stop_mode_i,
    input  wire logic       wait_mode_i,
    input  wire logic       hold_state_i,
    input  wire logic       sub_clock_sel_i,
    // Underflow actions
    output logic            wdt_irq_o,
    output logic            wdt_reset_o
);

    // Narrow counters serve short test periods; the read view caps it at 15
    if (COUNT_W < 2 || COUNT_W > CNT_W) begin : g_bad_width
        $error("Counter width must be 2 to 15");
    end

    localparam logic [COUNT_W-1:0] RELOAD  = CNT_RELOAD[COUNT_W-1:0];
    localparam logic [COUNT_W-1:0] CNT_ONE = COUNT_W'(1);

    bus_req_t   req;
    wdt_state_t state_ff;
    wdt_state_t nxt_state;
    logic [COUNT_W-1:0] count_ff;
    logic [CNT_W-1:0] count_view;
    logic [PRE_W-1:0] pre_ff;
    logic [PRE_W-1:0] div_top;
    logic       prescale_select_bit_ff;
    logic       underflow_action_select_ff;
    logic       sub_ff;
    logic [ST_WIDTH-1:0] irq_st_ff;
    logic [ST_WIDTH-1:0] irq_en_ff;
    logic       frozen;
    logic       restart_wr;
    logic       ctrl_wr;
    logic       tick;
    logic       underflow;
    logic       running;

    assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
    assign frozen     = stop_mode_i | wait_mode_i | hold_state_i;
    // Gate at once so a freeze never lets one more prescaler step through
    assign running    = (state_ff == ST_RUN) && !frozen;
    assign count_view = CNT_W'(count_ff);
    assign restart_wr = req.wr && (req.addr == OFS_RESTART);
    assign ctrl_wr    = req.wr && (req.addr == OFS_CTRL);

    // (R4) main clock ratio select
    // (R5) sub-clock forces divide by two
    always_comb begin
        if (sub_clock_sel_i) begin
            div_top = DIV_SUB;
        end else if (prescale_select_bit_ff) begin
            div_top = DIV_SLOW;
        end else begin
            div_top = DIV_FAST;
        end
    end

    assign tick      = running && (pre_ff >= div_top);
    assign underflow = tick && (count_ff == '0);

    // (R9) idle until first restart
    // (R10) freeze in low-power states
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (restart_wr) begin
                    nxt_state = frozen ? ST_HALT : ST_RUN;
                end
            end
            ST_RUN: begin
                if (frozen) begin
                    nxt_state = ST_HALT;
                end
            end
            ST_HALT: begin
                if (!frozen) begin
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // (R8) prescaler cleared by reset
    // (R6) restart also clears prescaler phase
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || restart_wr) begin
            pre_ff <= '0;
        end else if (tick) begin
            pre_ff <= '0;
        end else if (running) begin
            pre_ff <= pre_ff + 7'h01;
        end
    end

    // (R1) count down per prescaler pulse
    // (R7) restart reloads the counter
    // (R13) reload value is all ones
    // (R11) halt keeps the held value
    // (R14) wrap to full count after underflow
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            count_ff <= RELOAD;
        end else if (restart_wr) begin
            count_ff <= RELOAD;
        end else if (tick) begin
            count_ff <= count_ff - CNT_ONE;
        end
    end

    // (R3) action bit is set-only
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            prescale_select_bit_ff     <= CTRL_RST[BIT_PRESCALE];
            underflow_action_select_ff <= CTRL_RST[BIT_ACTION];
        end else if (ctrl_wr) begin
            prescale_select_bit_ff <= req.wdata[BIT_PRESCALE];
            if (req.wdata[BIT_ACTION]) begin
                underflow_action_select_ff <= 1'b1;
            end
        end
    end

    // (R2) underflow action dispatch; set wins over clear
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_st_ff <= '0;
        end else begin
            if (req.wr && req.addr == OFS_IRQ_CLR) begin
                irq_st_ff <= irq_st_ff & ~req.wdata[ST_WIDTH-1:0];
            end
            if (underflow && !underflow_action_select_ff) begin
                irq_st_ff[ST_UNDERFLOW] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_en_ff <= '0;
        end else if (req.wr && req.addr == OFS_IRQ_EN) begin
            irq_en_ff <= req.wdata[ST_WIDTH-1:0];
        end
    end

    assign wdt_irq_o = |(irq_st_ff & irq_en_ff);

    // Reset pulse is one cycle; the system reset path stretches it
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wdt_reset_o <= 1'b0;
        end else begin
            wdt_reset_o <= underflow && underflow_action_select_ff;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sub_ff <= 1'b0;
        end else begin
            sub_ff <= sub_clock_sel_i;
        end
    end

    // Read data one cycle after strobe; unmapped reads give zero
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                OFS_CTRL:    rdata_o <= {5'h00, sub_ff,
                                         underflow_action_select_ff,
                                         prescale_select_bit_ff};
                OFS_COUNT:   rdata_o <= {count_view[CNT_W-1:7] == '0,
                                         count_view[6:0]};
                OFS_IRQ_ST:  rdata_o <= {7'h00, irq_st_ff};
                OFS_IRQ_EN:  rdata_o <= {7'h00, irq_en_ff};
                default:     rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // Assertions
    a_idle_no_count: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == ST_IDLE |-> ##1 $stable(count_ff) || $past(restart_wr))
        else $error("Counter moved before first restart"); // (R9)
    a_halt_holds: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == ST_HALT && !restart_wr |=> $stable(count_ff))
        else $error("Counter moved while frozen"); // (R10)
    a_restart_reload: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        restart_wr |=> count_ff == RELOAD)
        else $error("Restart did not reload"); // (R7)
    a_action_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        underflow_action_select_ff |=> underflow_action_select_ff)
        else $error("Action bit cleared"); // (R3)
    a_sub_div_two: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        sub_clock_sel_i |-> div_top == DIV_SUB)
        else $error("Sub-clock ratio wrong"); // (R5)
    a_main_div: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !sub_clock_sel_i |-> div_top == (prescale_select_bit_ff ?
                                         DIV_SLOW : DIV_FAST))
        else $error("Main-clock ratio wrong"); // (R4)
    a_reset_action: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        underflow && underflow_action_select_ff |=> wdt_reset_o)
        else $error("Underflow reset missing"); // (R2)
    a_irq_action: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        underflow && !underflow_action_select_ff |=>
        irq_st_ff[ST_UNDERFLOW] && !wdt_reset_o)
        else $error("Underflow interrupt missing"); // (R2)
    a_wrap_full: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        underflow && !restart_wr |=> count_ff == RELOAD)
        else $error("No wrap after underflow"); // (R14)
    a_tick_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        tick && !restart_wr && count_ff != '0 |=>
        count_ff == $past(count_ff) - CNT_ONE)
        else $error("Counter step wrong"); // (R1)
    a_fast_spacing: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        tick && !sub_clock_sel_i && !prescale_select_bit_ff |=>
        !tick [*8])
        else $error("Prescaler pulses too close"); // (R6)

    // Counter and prescaler
    a_idle_prescaler: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == ST_IDLE |-> pre_ff == '0)
        else $error("Prescaler ran before first restart"); // (R9)
    a_no_tick_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff != ST_RUN |-> !tick)
        else $error("Tick outside run state"); // (R9)
    a_idle_start: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == ST_IDLE && restart_wr && !frozen |=> state_ff == ST_RUN)
        else $error("First restart did not start counting"); // (R9)
    a_restart_frozen: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == ST_IDLE && restart_wr && frozen |=> state_ff == ST_HALT)
        else $error("Restart while frozen started counting"); // (R10)
    a_frozen_stops: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        frozen && !restart_wr |=> $stable(count_ff) && $stable(pre_ff))
        else $error("Counting while frozen"); // (R10)
    a_halt_prescaler: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == ST_HALT && !restart_wr |=> $stable(pre_ff))
        else $error("Prescaler moved in halt"); // (R10)
    a_resume_held: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == ST_HALT && !frozen && !restart_wr |=>
        count_ff == $past(count_ff))
        else $error("Count reloaded on resume"); // (R11)
    a_restart_prescaler: assert property (@(posedge sys_clk_i)
        disable iff (rst_i)
        restart_wr |=> pre_ff == '0)
        else $error("Restart left prescaler phase"); // (R6)
    a_slow_spacing: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        tick && !sub_clock_sel_i && prescale_select_bit_ff |=> !tick [*8])
        else $error("Slow prescaler pulses too close"); // (R4)
    a_sub_spacing: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        tick && sub_clock_sel_i |=> !tick)
        else $error("Sub-clock pulses too close"); // (R5)

    // Control bits, action and status
    a_prescale_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ctrl_wr |=> prescale_select_bit_ff == $past(req.wdata[BIT_PRESCALE]))
        else $error("Prescale bit not written"); // (R4)
    a_action_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ctrl_wr && req.wdata[BIT_ACTION] |=> underflow_action_select_ff)
        else $error("Action bit not set"); // (R3)
    a_reset_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wdt_reset_o |=> !wdt_reset_o)
        else $error("Reset pulse too long"); // (R2)
    a_no_reset_irq: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !underflow_action_select_ff |=> !wdt_reset_o)
        else $error("Reset in interrupt action"); // (R2)
    a_status_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_st_ff[ST_UNDERFLOW] && !(req.wr && req.addr == OFS_IRQ_CLR) |=>
        irq_st_ff[ST_UNDERFLOW])
        else $error("Status bit lost"); // (R2)
    a_clear_status: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        req.wr && req.addr == OFS_IRQ_CLR && req.wdata[ST_UNDERFLOW] &&
        !underflow |=> !irq_st_ff[ST_UNDERFLOW])
        else $error("Status bit not cleared"); // (R2)

    // Register port
    a_en_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        req.wr && req.addr == OFS_IRQ_EN |=>
        irq_en_ff == $past(req.wdata[ST_WIDTH-1:0]))
        else $error("Enable register not written");
    a_read_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !req.rd |=> rdata_o == 8'h00)
        else $error("Read data outside read cycle");
    a_count_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        req.rd && req.addr == OFS_COUNT |=>
        rdata_o[6:0] == $past(count_view[6:0]))
        else $error("Count view wrong");

    c_sub_underflow: cover property (@(posedge sys_clk_i)
        underflow && sub_clock_sel_i);
    c_restart_frozen: cover property (@(posedge sys_clk_i)
        state_ff == ST_IDLE && restart_wr && frozen);
    c_underflow_irq: cover property (@(posedge sys_clk_i)
        underflow && !underflow_action_select_ff);
    c_underflow_rst: cover property (@(posedge sys_clk_i) wdt_reset_o);
    c_halt_resume: cover property (@(posedge sys_clk_i)
        state_ff == ST_HALT ##1 state_ff == ST_RUN);
endmodule

// >>> sim/program_runaway_watchdog_tb.sv
// Self-checking bench for the runaway watchdog
`timescale 1ns/1ns
module program_runaway_watchdog_tb;
    import wdt_pkg::*;
    // Short counter keeps the full periods within a quick run
    localparam int          CW       = 6;
    localparam int          TOP      = 2**CW;
    localparam logic [7:0]  CNT_FULL = {1'b1, 7'(TOP - 1)};
    typedef struct packed {
        logic [3:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;
    logic       sys_clk_i;
    logic       rst_i;
    logic [3:0] addr_i;
    logic [7:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    logic [7:0] rdata_o;
    logic       stop_mode_i;
    logic       wait_mode_i;
    logic       hold_state_i;
    logic       sub_clock_sel_i;
    logic       wdt_irq_o;
    logic       wdt_reset_o;
    int         n_errors;
    int         checks_done;
    row_t       rows [6];

    program_runaway_watchdog #(.COUNT_W(CW)) i_program_runaway_watchdog (
        .sys_clk_i      (sys_clk_i),
        .rst_i          (rst_i),
        .addr_i         (addr_i),
        .wdata_i        (wdata_i),
        .wr_i           (wr_i),
        .rd_i           (rd_i),
        .rdata_o        (rdata_o),
        .stop_mode_i    (stop_mode_i),
        .wait_mode_i    (wait_mode_i),
        .hold_state_i   (hold_state_i),
        .sub_clock_sel_i(sub_clock_sel_i),
        .wdt_irq_o      (wdt_irq_o),
        .wdt_reset_o    (wdt_reset_o)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    // Counts cycles to the event; overrunning the window ends the run
    task automatic wait_evt(input logic use_rst, input int exp, input int tol);
        int n;
        for (n = 1; n <= exp + tol; n++) begin
            @(posedge sys_clk_i);
            #1;
            if ((use_rst ? wdt_reset_o : wdt_irq_o) === 1'b1)
                break;
        end
        checks_done++;
        if (n < exp - tol || n > exp + tol) begin
            n_errors++;
            $display("[FAIL] %0t event after %0d cycles, not %0d", $time, n, exp);
            if (n > exp + tol)
                summarize();
        end
    endtask

    initial begin
        rst_i = 1'b1;
        {wr_i, rd_i, addr_i, wdata_i} = '0;
        {stop_mode_i, wait_mode_i, hold_state_i, sub_clock_sel_i} = '0;
        n_errors    = 0;
        checks_done = 0;
        rows = '{'{OFS_IRQ_EN, 8'h01, 8'h01}, '{OFS_IRQ_EN, 8'h00, 8'h00},
                 '{OFS_IRQ_ST, 8'h01, 8'h00}, '{4'h3, 8'hff, 8'h00},
                 '{OFS_CTRL, 8'h01, 8'h01}, '{OFS_CTRL, 8'h00, 8'h00}};
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        wr(OFS_IRQ_EN, 8'h01);
        repeat (1500) @(posedge sys_clk_i);
        rd(OFS_COUNT, CNT_FULL);
        chk({7'h00, wdt_irq_o}, 8'h00);
        wr(OFS_RESTART, 8'h5a);
        rd(OFS_COUNT, CNT_FULL);
        wait_evt(1'b0, 16 * TOP, 20);
        rd(OFS_IRQ_ST, 8'h01);
        wr(OFS_IRQ_CLR, 8'h01);
        rd(OFS_IRQ_ST, 8'h00);
        wait_evt(1'b0, 16 * TOP, 24);
        wr(OFS_IRQ_CLR, 8'h01);
        wr(OFS_RESTART, 8'h00);
        repeat (500) @(posedge sys_clk_i);
        wr(OFS_RESTART, 8'h00);
        wait_evt(1'b0, 16 * TOP, 20);
        wr(OFS_IRQ_CLR, 8'h01);
        sub_clock_sel_i <= 1'b1;
        wr(OFS_CTRL, 8'h01);
        rd(OFS_CTRL, 8'h05);
        wr(OFS_RESTART, 8'h00);
        wait_evt(1'b0, 2 * TOP, 4);
        wr(OFS_IRQ_CLR, 8'h01);
        sub_clock_sel_i <= 1'b0;
        wr(OFS_RESTART, 8'h00);
        wait_evt(1'b0, 128 * TOP, 140);
        wr(OFS_CTRL, 8'h00);
        // A reload on release would show as a late event
        for (int k = 0; k < 3; k++) begin
            wr(OFS_IRQ_CLR, 8'h01);
            wr(OFS_RESTART, 8'h00);
            repeat (300) @(posedge sys_clk_i);
            {stop_mode_i, wait_mode_i, hold_state_i} <= 3'b100 >> k;
            repeat (2000) @(posedge sys_clk_i);
            {stop_mode_i, wait_mode_i, hold_state_i} <= 3'b000;
            wait_evt(1'b0, 16 * TOP - 300, 24);
        end
        wr(OFS_IRQ_CLR, 8'h01);
        wr(OFS_CTRL, 8'h02);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_CTRL, 8'h02);
        wr(OFS_RESTART, 8'h00);
        wait_evt(1'b1, 16 * TOP, 20);
        @(posedge sys_clk_i);
        #1;
        chk({7'h00, wdt_reset_o}, 8'h00);
        rd(OFS_IRQ_ST, 8'h00);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd(OFS_CTRL, CTRL_RST);
        rd(OFS_COUNT, CNT_FULL);
        // First restart while frozen must load but not count
        stop_mode_i <= 1'b1;
        wr(OFS_RESTART, 8'h00);
        repeat (40) @(posedge sys_clk_i);
        rd(OFS_COUNT, CNT_FULL);
        stop_mode_i <= 1'b0;
        summarize();
    end
endmodule
